/* File: verilog/crf_pkg.sv */
// Purpose: Shared constants and carrier types for the core register file
// Assumes: One clock domain, register port indexed by word
// Notes:   Indices 0..15 are the core registers, the rest special registers
package crf_pkg;

	// -------------------------------------------------------------
	// Register port indices
	// -------------------------------------------------------------
	localparam logic [4:0] CRF_IDX_SP       = 5'h0D;
	localparam logic [4:0] CRF_IDX_LR       = 5'h0E;
	localparam logic [4:0] CRF_IDX_PC       = 5'h0F;
	localparam logic [4:0] CRF_IDX_PSW      = 5'h10;
	localparam logic [4:0] CRF_IDX_APP      = 5'h11;
	localparam logic [4:0] CRF_IDX_INT      = 5'h12;
	localparam logic [4:0] CRF_IDX_EXEC     = 5'h13;
	localparam logic [4:0] CRF_IDX_PRIMARY_INTERRUPT_MASK  = 5'h14;
	localparam logic [4:0] CRF_IDX_FAULTMSK = 5'h15;
	localparam logic [4:0] CRF_IDX_PRIO     = 5'h16;
	localparam logic [4:0] CRF_IDX_CONTROL  = 5'h17;
	localparam logic [4:0] CRF_IDX_EVT_STAT = 5'h18;
	localparam logic [4:0] CRF_IDX_EVT_MASK = 5'h19;
	localparam logic [4:0] CRF_IDX_MAIN_SP  = 5'h1A;
	localparam logic [4:0] CRF_IDX_PROC_SP  = 5'h1B;

	// -------------------------------------------------------------
	// Register counts and field layout
	// -------------------------------------------------------------
	localparam int          CRF_NUM_GPR     = 13;
	localparam logic [3:0]  CRF_LOW_TOP     = 4'h7;
	localparam logic [31:0] CRF_APP_MASK    = 32'hF8000000;
	localparam logic [31:0] CRF_INT_MASK    = 32'h000001FF;
	localparam logic [31:0] CRF_EXEC_MASK   = 32'h0600FC00;
	localparam int          CRF_EXEC_T_BIT  = 24;
	localparam logic [31:0] CRF_SP_MASK     = 32'hFFFFFFFC;
	localparam logic [31:0] CRF_PC_MASK     = 32'hFFFFFFFE;
	localparam int          CRF_CTRL_USER   = 0;
	localparam int          CRF_CTRL_STACK  = 1;

	// Event bits of the status and mask registers
	localparam int          CRF_EVT_PRIV    = 0;
	localparam int          CRF_EVT_TCLR    = 1;
	localparam int          CRF_EVT_NARROW  = 2;
	localparam int          CRF_EVT_W       = 3;

	// -------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------
	localparam logic [31:0] CRF_RST_WORD    = 32'h00000000;
	localparam logic [31:0] CRF_RST_EXEC    = 32'h01000000;
	localparam logic [8:0]  CRF_RST_PRIO    = 9'h000;
	localparam logic [1:0]  CRF_RST_CONTROL = 2'h0;

	// -------------------------------------------------------------
	// Carrier types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		CRF_IRQ_NORMAL,
		CRF_IRQ_HARDFAULT,
		CRF_IRQ_NMI
	} crf_irq_kind_t;

	typedef struct packed {
		logic          valid;
		crf_irq_kind_t kind;
		logic [8:0]    prio;
	} crf_irq_req_t;

	typedef struct packed {
		logic        valid;
		logic        narrow;
		logic [3:0]  idx;
	} crf_rd_req_t;

	typedef struct packed {
		logic        valid;
		logic        narrow;
		logic [3:0]  idx;
		logic [31:0] data;
	} crf_wr_req_t;

	typedef struct packed {
		logic        enter;
		logic        leave;
		logic [8:0]  num;
	} crf_exc_t;

endpackage : crf_pkg

/* File: verilog/crf_core_regs.sv */
// Purpose: Architectural registers, status word and interrupt masking
// Assumes: Inputs synchronous to clk_sys, one-cycle strobes
// Notes:   Read port and register port answer one cycle after the request
`timescale 1ns/1ps

// How it works
// - Stack pointer banked, process bank only user thread
// - Stack pointer low two bits read zero
// - Program counter bit zero reads zero
// - Calls store return address in link register
// - Narrow instructions reach registers zero-seven and 13-15, not 8-12
// - Status word accessed whole or per part
// - Result flags live in bits 27-31
// - Exception number in nine low bits
// - Continuation state bits 10-15 and 25-26
// - Bit 24 stays one; clearing faults
// - Primary mask leaves only NMI, hard fault
// - Fault mask leaves only NMI
// - Nonzero threshold blocks equal or higher values
// - Control bit zero selects user thread level
// - Control bit one picks stack at user thread level only; zero in handler
// - Sixteen core registers all 32 bits wide
// - User level special access, except to APP, refused with fault
// - Handler mode during exceptions, always privileged
module crf_core_regs (
	input  wire logic                  clk_sys,     // System clock
	input  wire logic                  rst_n,       // Async reset, active low
	input  wire logic [4:0]            reg_addr,    // Register index
	input  wire logic [31:0]           reg_wdata,   // Write data
	input  wire logic                  reg_wr,      // Write strobe
	input  wire logic                  reg_rd,      // Read strobe
	output logic      [31:0]           reg_rdata,   // Read data, next cycle
	input  wire crf_pkg::crf_rd_req_t  rd_req,      // Pipeline operand read
	output logic      [31:0]           rd_data,     // Operand, next cycle
	input  wire crf_pkg::crf_wr_req_t  wr_req,      // Pipeline result write
	input  wire logic                  call_en,     // Subroutine call
	input  wire logic [31:0]           call_ret,    // Return address
	input  wire logic                  pc_load,     // Program counter load
	input  wire logic [31:0]           pc_next,     // New program counter
	input  wire logic                  flags_wr,    // Result flags update
	input  wire logic [4:0]            flags_val,   // Flags for bits 31:27
	input  wire crf_pkg::crf_exc_t     exc,         // Exception entry/leave
	input  wire crf_pkg::crf_irq_req_t irq_req,     // Candidate interrupt
	output logic                       irq_take,    // Candidate accepted
	output logic [31:0]                pc,          // Aligned program counter
	output logic                       fault_pulse, // Fault exception request
	output logic                       evt_irq      // Unmasked event pending
);
	import crf_pkg::*;

	// -------------------------------------------------------------
	// State
	// -------------------------------------------------------------
	logic [31:0]          gpr [CRF_NUM_GPR];
	logic [31:0]          main_sp;
	logic [31:0]          proc_sp;
	logic [31:0]          lr;
	logic [31:0]          app_st;
	logic [31:0]          int_st;
	logic [31:0]          exec_st;
	logic                 primary_interrupt_mask;
	logic                 fault_level_mask;
	logic [8:0]           priority_threshold;
	logic [1:0]           ctrl;
	logic                 ctrl_stack_saved;
	logic                 handler;
	logic [CRF_EVT_W-1:0] evt_status;
	logic [CRF_EVT_W-1:0] evt_mask;

	// -------------------------------------------------------------
	// Decoding helpers
	// -------------------------------------------------------------
	function automatic logic is_special(input logic [4:0] a);
		is_special = (a >= CRF_IDX_PSW) && (a != CRF_IDX_APP);
	endfunction : is_special

	function automatic logic is_high(input logic [3:0] i);
		is_high = (i > CRF_LOW_TOP) && (i < 4'(CRF_NUM_GPR));
	endfunction : is_high

	wire logic        privileged  = handler | ~ctrl[CRF_CTRL_USER];
	wire logic        use_psp     = ~handler & ctrl[CRF_CTRL_USER]
	                                & ctrl[CRF_CTRL_STACK];
	wire logic [31:0] active_sp   = (use_psp ? proc_sp : main_sp) & CRF_SP_MASK;
	wire logic [31:0] psw_word    = (app_st & CRF_APP_MASK) | (int_st & CRF_INT_MASK)
	                                | (exec_st & (CRF_EXEC_MASK | CRF_RST_EXEC));
	wire logic        user_viol   = (reg_wr | reg_rd) & ~privileged
	                                & is_special(reg_addr);
	wire logic        bus_wr      = reg_wr & ~user_viol;
	wire logic        rd_narrow_x = rd_req.valid & rd_req.narrow & is_high(rd_req.idx);
	wire logic        wr_narrow_x = wr_req.valid & wr_req.narrow & is_high(wr_req.idx);
	wire logic        pipe_wr     = wr_req.valid & ~wr_narrow_x;
	wire logic        psw_wr      = bus_wr & (reg_addr == CRF_IDX_PSW);
	wire logic        exec_wr     = psw_wr | (bus_wr & (reg_addr == CRF_IDX_EXEC));
	wire logic        app_wr      = psw_wr | (bus_wr & (reg_addr == CRF_IDX_APP));
	wire logic        t_clear     = exec_wr & ~reg_wdata[CRF_EXEC_T_BIT];

	// Pipeline write wins over the register port in the same cycle
	wire logic        sp_wr       = (pipe_wr & (wr_req.idx == CRF_IDX_SP[3:0]))
	                                | (~pipe_wr & bus_wr & (reg_addr == CRF_IDX_SP));
	wire logic [31:0] sp_wdata    = (pipe_wr ? wr_req.data : reg_wdata) & CRF_SP_MASK;

	function automatic logic [31:0] core_read(input logic [4:0] a);
		core_read = 32'h00000000;
		if (a < 5'(CRF_NUM_GPR)) begin
			core_read = gpr[a[3:0]];
		end else begin
			case (a)
				CRF_IDX_SP:       core_read = active_sp;
				CRF_IDX_LR:       core_read = lr;
				CRF_IDX_PC:       core_read = pc & CRF_PC_MASK;
				CRF_IDX_PSW:      core_read = psw_word;
				CRF_IDX_APP:      core_read = app_st & CRF_APP_MASK;
				CRF_IDX_INT:      core_read = int_st & CRF_INT_MASK;
				CRF_IDX_EXEC:     core_read = exec_st & (CRF_EXEC_MASK | CRF_RST_EXEC);
				CRF_IDX_PRIMARY_INTERRUPT_MASK:  core_read = {31'h00000000, primary_interrupt_mask};
				CRF_IDX_FAULTMSK: core_read = {31'h00000000, fault_level_mask};
				CRF_IDX_PRIO:     core_read = {23'h000000, priority_threshold};
				CRF_IDX_CONTROL:  core_read = {30'h00000000, ctrl};
				CRF_IDX_EVT_STAT: core_read = {29'h00000000, evt_status};
				CRF_IDX_EVT_MASK: core_read = {29'h00000000, evt_mask};
				CRF_IDX_MAIN_SP:  core_read = main_sp & CRF_SP_MASK;
				CRF_IDX_PROC_SP:  core_read = proc_sp & CRF_SP_MASK;
				default:          core_read = 32'h00000000;
			endcase
		end
	endfunction : core_read

	// -------------------------------------------------------------
	// General registers
	// -------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < CRF_NUM_GPR; gi++) begin : g_gpr
			wire logic pw = pipe_wr & (wr_req.idx == 4'(gi));
			wire logic bw = ~pipe_wr & bus_wr & (reg_addr == 5'(gi));
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					gpr[gi] <= CRF_RST_WORD;
				end else if (pw) begin
					gpr[gi] <= wr_req.data;
				end else if (bw) begin
					gpr[gi] <= reg_wdata;
				end
			end
		end
	endgenerate

	// -------------------------------------------------------------
	// Stack pointers, link register, program counter
	// -------------------------------------------------------------
	wire logic main_wr = (sp_wr & ~use_psp) | (bus_wr & (reg_addr == CRF_IDX_MAIN_SP));
	wire logic proc_wr = (sp_wr & use_psp) | (bus_wr & (reg_addr == CRF_IDX_PROC_SP));
	wire logic [31:0] next_main_sp = (sp_wr & ~use_psp) ? sp_wdata : reg_wdata & CRF_SP_MASK;
	wire logic [31:0] next_proc_sp = (sp_wr & use_psp) ? sp_wdata : reg_wdata & CRF_SP_MASK;
	wire logic lr_pipe = pipe_wr & (wr_req.idx == CRF_IDX_LR[3:0]);
	wire logic lr_bus  = bus_wr & (reg_addr == CRF_IDX_LR);
	wire logic pc_pipe = pipe_wr & (wr_req.idx == CRF_IDX_PC[3:0]);
	wire logic pc_bus  = bus_wr & (reg_addr == CRF_IDX_PC);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			main_sp <= CRF_RST_WORD;
			proc_sp <= CRF_RST_WORD;
		end else begin
			if (main_wr) begin
				main_sp <= next_main_sp;
			end
			if (proc_wr) begin
				proc_sp <= next_proc_sp;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lr <= CRF_RST_WORD;
		end else if (call_en) begin
			lr <= call_ret;
		end else if (lr_pipe) begin
			lr <= wr_req.data;
		end else if (lr_bus) begin
			lr <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pc <= CRF_RST_WORD;
		end else if (pc_load) begin
			pc <= pc_next & CRF_PC_MASK;
		end else if (pc_pipe) begin
			pc <= wr_req.data & CRF_PC_MASK;
		end else if (pc_bus) begin
			pc <= reg_wdata & CRF_PC_MASK;
		end
	end

	// -------------------------------------------------------------
	// Status word parts
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			app_st  <= CRF_RST_WORD;
			exec_st <= CRF_RST_EXEC;
		end else begin
			if (flags_wr) begin
				app_st <= {flags_val, 27'h0000000};
			end else if (app_wr) begin
				app_st <= reg_wdata & CRF_APP_MASK;
			end
			if (exec_wr) begin
				exec_st <= (reg_wdata & CRF_EXEC_MASK) | CRF_RST_EXEC;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			int_st           <= CRF_RST_WORD;
			handler          <= 1'b0;
			ctrl             <= CRF_RST_CONTROL;
			ctrl_stack_saved <= 1'b0;
		end else if (exc.enter) begin
			int_st  <= {23'h000000, exc.num};
			handler <= 1'b1;
			if (!handler) begin
				ctrl_stack_saved <= ctrl[CRF_CTRL_STACK];
			end
			ctrl[CRF_CTRL_STACK] <= 1'b0;
		end else if (exc.leave) begin
			int_st               <= CRF_RST_WORD;
			handler              <= 1'b0;
			ctrl[CRF_CTRL_STACK] <= ctrl_stack_saved;
		end else if (bus_wr && reg_addr == CRF_IDX_CONTROL) begin
			ctrl[CRF_CTRL_USER]  <= reg_wdata[CRF_CTRL_USER];
			ctrl[CRF_CTRL_STACK] <= reg_wdata[CRF_CTRL_STACK] & ~handler;
		end
	end

	// -------------------------------------------------------------
	// Interrupt masking registers and acceptance
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			primary_interrupt_mask <= 1'b0;
			fault_level_mask       <= 1'b0;
			priority_threshold     <= CRF_RST_PRIO;
		end else begin
			if (bus_wr && reg_addr == CRF_IDX_PRIMARY_INTERRUPT_MASK) begin
				primary_interrupt_mask <= reg_wdata[0];
			end
			if (bus_wr && reg_addr == CRF_IDX_FAULTMSK) begin
				fault_level_mask <= reg_wdata[0];
			end
			if (bus_wr && reg_addr == CRF_IDX_PRIO) begin
				priority_threshold <= reg_wdata[8:0];
			end
		end
	end

	wire logic prio_block = (priority_threshold != 9'h000)
	                        && (irq_req.prio >= priority_threshold);
	logic accept;
	always_comb begin
		case (irq_req.kind)
			CRF_IRQ_NMI:       accept = 1'b1;
			CRF_IRQ_HARDFAULT: accept = ~fault_level_mask;
			CRF_IRQ_NORMAL:    accept = ~fault_level_mask & ~primary_interrupt_mask
			                            & ~prio_block;
			default:           accept = 1'b0;
		endcase
	end
	wire logic next_irq_take = irq_req.valid & accept;

	// -------------------------------------------------------------
	// Fault events, status and interrupt
	// -------------------------------------------------------------
	wire logic [CRF_EVT_W-1:0] evt_set = {rd_narrow_x | wr_narrow_x, t_clear, user_viol};
	wire logic [CRF_EVT_W-1:0] evt_clr = (bus_wr && reg_addr == CRF_IDX_EVT_STAT)
	                                     ? reg_wdata[CRF_EVT_W-1:0] : '0;
	wire logic [CRF_EVT_W-1:0] next_evt_status = (evt_status & ~evt_clr) | evt_set;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evt_status <= '0;
			evt_mask   <= '0;
		end else begin
			evt_status <= next_evt_status;
			if (bus_wr && reg_addr == CRF_IDX_EVT_MASK) begin
				evt_mask <= reg_wdata[CRF_EVT_W-1:0];
			end
		end
	end

	// -------------------------------------------------------------
	// Registered outputs
	// -------------------------------------------------------------
	wire logic [31:0] next_reg_rdata = (reg_rd && !user_viol) ? core_read(reg_addr) : '0;
	wire logic [31:0] next_rd_data   = (rd_req.valid && !rd_narrow_x)
	                                   ? core_read({1'b0, rd_req.idx}) : '0;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata   <= CRF_RST_WORD;
			rd_data     <= CRF_RST_WORD;
			irq_take    <= 1'b0;
			fault_pulse <= 1'b0;
			evt_irq     <= 1'b0;
		end else begin
			reg_rdata   <= next_reg_rdata;
			rd_data     <= next_rd_data;
			irq_take    <= next_irq_take;
			fault_pulse <= |evt_set;
			evt_irq     <= |(next_evt_status & evt_mask);
		end
	end

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	property p_sp_align;
		@(posedge clk_sys) disable iff (!rst_n)
		rd_req.valid && rd_req.idx == CRF_IDX_SP[3:0] |=> rd_data[1:0] == 2'h0;
	endproperty
	a_sp_align: assert property (p_sp_align) else $error("sp low bits set");

	property p_pc_align;
		@(posedge clk_sys) disable iff (!rst_n)
		pc_load |=> pc == ($past(pc_next) & CRF_PC_MASK);
	endproperty
	a_pc_align: assert property (p_pc_align) else $error("pc load wrong");

	property p_call_lr;
		@(posedge clk_sys) disable iff (!rst_n)
		call_en |=> lr == $past(call_ret);
	endproperty
	a_call_lr: assert property (p_call_lr) else $error("lr not stored");

	property p_narrow;
		@(posedge clk_sys) disable iff (!rst_n)
		rd_req.valid && rd_req.narrow && is_high(rd_req.idx)
		|=> fault_pulse && rd_data == 32'h00000000;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow high read passed");

	property p_tclear;
		@(posedge clk_sys) disable iff (!rst_n)
		exec_wr && !reg_wdata[CRF_EXEC_T_BIT] |=> fault_pulse && exec_st[CRF_EXEC_T_BIT];
	endproperty
	a_tclear: assert property (p_tclear) else $error("t bit clear no fault");

	property p_primary_interrupt_mask;
		@(posedge clk_sys) disable iff (!rst_n)
		irq_req.valid && irq_req.kind == CRF_IRQ_NORMAL && primary_interrupt_mask
		|=> !irq_take;
	endproperty
	a_primary_interrupt_mask: assert property (p_primary_interrupt_mask) else $error("primary_interrupt_mask ignored");

	property p_fault_level_mask;
		@(posedge clk_sys) disable iff (!rst_n)
		irq_req.valid && fault_level_mask |=> irq_take == ($past(irq_req.kind) == CRF_IRQ_NMI);
	endproperty
	a_fault_level_mask: assert property (p_fault_level_mask) else $error("fault_level_mask wrong");

	property p_prio;
		@(posedge clk_sys) disable iff (!rst_n)
		irq_req.valid && irq_req.kind == CRF_IRQ_NORMAL && priority_threshold != 9'h000
		&& irq_req.prio >= priority_threshold |=> !irq_take;
	endproperty
	a_prio: assert property (p_prio) else $error("threshold ignored");

	property p_handler_stack;
		@(posedge clk_sys) disable iff (!rst_n)
		exc.enter |=> handler && !ctrl[CRF_CTRL_STACK] && int_st[8:0] == $past(exc.num);
	endproperty
	a_handler_stack: assert property (p_handler_stack) else $error("handler entry");

	property p_user_refuse;
		@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && !privileged && is_special(reg_addr)
		|=> fault_pulse && $stable(ctrl[CRF_CTRL_USER]);
	endproperty
	a_user_refuse: assert property (p_user_refuse) else $error("user write passed");

endmodule : crf_core_regs

/* File: verification/crf_pipe_model.sv */
// Purpose: Pipeline and exception side model for the core register file
// Assumes: Driven at rising edges, one-cycle requests
// Notes:   Released number and priority fields show inverted values
`timescale 1ns/1ps

module crf_pipe_model
	import crf_pkg::*;
(
	input  wire logic          clk_sys,  // System clock
	output crf_pkg::crf_exc_t  exc,      // Exception entry and leave
	output crf_pkg::crf_irq_req_t irq_req, // Candidate interrupt
	input  wire logic          irq_take  // Candidate accepted
);
	initial begin
		exc     = '0;
		irq_req = '0;
	end

	// -------------------------------------------------------------
	// Exception sequencing
	// -------------------------------------------------------------
	task automatic enter(input logic [8:0] num);
		@(posedge clk_sys);
		exc <= {1'b1, 1'b0, num};
		@(posedge clk_sys);
		exc <= {1'b0, 1'b0, ~num};
	endtask : enter

	task automatic leave();
		@(posedge clk_sys);
		exc <= {1'b0, 1'b1, exc.num};
		@(posedge clk_sys);
		exc <= {1'b0, 1'b0, ~exc.num};
	endtask : leave

	// -------------------------------------------------------------
	// Interrupt request, answer sampled one cycle later
	// -------------------------------------------------------------
	task automatic irq(input crf_irq_kind_t kind, input logic [8:0] prio, output logic took);
		@(posedge clk_sys);
		irq_req <= {1'b1, kind, prio};
		@(posedge clk_sys);
		irq_req <= {1'b0, kind, ~prio};
		#1 took = irq_take;
	endtask : irq
endmodule : crf_pipe_model

/* File: verification/test_crf_core_regs.sv */
// Purpose: Self-checking bench for the core register file
// Assumes: Fixed one-cycle answers on all ports
// Notes:   Fault pulses are counted by a monitor
`timescale 1ns/1ps

module test_crf_core_regs;
	import crf_pkg::*;
	logic clk_sys, rst_n, reg_wr, reg_rd, call_en, pc_load, irq_take, fault_pulse, evt_irq, tk;
	logic        flags_wr;
	logic [4:0]  reg_addr, flags_val;
	logic [31:0] reg_wdata, reg_rdata, rd_data, call_ret, pc_next, pc;
	crf_rd_req_t rd_req;
	crf_wr_req_t wr_req;
	crf_exc_t    exc;
	crf_irq_req_t irq_req;
	int n_fail = 0, cmp_count = 0, n_flt = 0;

	crf_core_regs i_crf_core_regs (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rd_req(rd_req), .rd_data(rd_data), .wr_req(wr_req), .call_en(call_en),
		.call_ret(call_ret), .pc_load(pc_load), .pc_next(pc_next), .flags_wr(flags_wr),
		.flags_val(flags_val), .exc(exc), .irq_req(irq_req), .irq_take(irq_take), .pc(pc),
		.fault_pulse(fault_pulse), .evt_irq(evt_irq));
	crf_pipe_model i_crf_pipe_model (.clk_sys(clk_sys), .exc(exc), .irq_req(irq_req),
		.irq_take(irq_take));

	initial begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (fault_pulse === 1'b1) n_flt++;

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0; reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic flt(input int exp);
		repeat (2) @(posedge clk_sys);
		chk(n_flt, exp);
	endtask : flt
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test

	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	task automatic t_align();
		logic [31:0] d;
		wr(CRF_IDX_SP, 32'hFFFFFFFF); rd(CRF_IDX_SP, d); chk(d, 32'hFFFFFFFC);
		@(posedge clk_sys); rd_req <= {1'b1, 1'b0, 4'hD};
		@(posedge clk_sys); rd_req <= '0;
		#1 chk(rd_data, 32'hFFFFFFFC);
		@(posedge clk_sys); pc_load <= 1'b1; pc_next <= 32'h00001235;
		@(posedge clk_sys); pc_load <= 1'b0; pc_next <= 32'hFFFFEDCA;
		#1 chk(pc, 32'h00001234);
		@(posedge clk_sys); call_en <= 1'b1; call_ret <= 32'h00000ABC;
		@(posedge clk_sys); call_en <= 1'b0; call_ret <= 32'hFFFFF543;
		rd(CRF_IDX_LR, d); chk(d, 32'h00000ABC);
		$display("test align done");
	endtask : t_align
	task automatic t_narrow();
		wr(5'h09, 32'hDEADBEEF);
		@(posedge clk_sys); rd_req <= {1'b1, 1'b0, 4'h9};
		@(posedge clk_sys); rd_req <= {1'b1, 1'b1, 4'h9};
		#1 chk(rd_data, 32'hDEADBEEF);
		@(posedge clk_sys); rd_req <= '0; wr_req <= {1'b1, 1'b1, 4'h9, 32'h00000055};
		#1 chk(rd_data, 32'h00000000);
		@(posedge clk_sys); wr_req <= {1'b1, 1'b1, 4'h3, 32'h00000077};
		@(posedge clk_sys); wr_req <= {1'b0, 1'b1, 4'h3, 32'hFFFFFF88}; rd_req <= {1'b1, 1'b0, 4'h9};
		@(posedge clk_sys); rd_req <= {1'b1, 1'b1, 4'h3};
		#1 chk(rd_data, 32'hDEADBEEF);
		@(posedge clk_sys); rd_req <= '0;
		#1 chk(rd_data, 32'h00000077);
		flt(2);
		$display("test narrow done");
	endtask : t_narrow
	task automatic t_status();
		logic [31:0] d;
		rd(CRF_IDX_EXEC, d); chk(d, CRF_RST_EXEC);
		wr(CRF_IDX_EXEC, 32'h0600FC00); flt(3);
		rd(CRF_IDX_EXEC, d); chk(d, 32'h0700FC00);
		wr(CRF_IDX_APP, 32'hFFFFFFFF); rd(CRF_IDX_APP, d); chk(d, 32'hF8000000);
		rd(CRF_IDX_PSW, d); chk(d, 32'hFF00FC00);
		wr(CRF_IDX_PSW, 32'h89001400); rd(CRF_IDX_PSW, d); chk(d, 32'h89001400);
		rd(CRF_IDX_EXEC, d); chk(d, 32'h01001400);
		@(posedge clk_sys); flags_wr <= 1'b1; flags_val <= 5'h15;
		@(posedge clk_sys); flags_wr <= 1'b0; flags_val <= 5'h0A;
		rd(CRF_IDX_APP, d); chk(d, 32'hA8000000);
		$display("test status done");
	endtask : t_status
	task automatic irq_case(input logic pm, fm, input logic [8:0] thr, input crf_irq_kind_t k,
		input logic [8:0] p, input logic exp);
		wr(CRF_IDX_PRIMARY_INTERRUPT_MASK, {31'h0, pm});
		wr(CRF_IDX_FAULTMSK, {31'h0, fm});
		wr(CRF_IDX_PRIO, {23'h0, thr});
		i_crf_pipe_model.irq(k, p, tk);
		chk(tk, exp);
	endtask : irq_case
	task automatic t_irq();
		irq_case(0, 0, 9'h000, CRF_IRQ_NORMAL, 9'h005, 1);
		irq_case(1, 0, 9'h000, CRF_IRQ_NORMAL, 9'h005, 0);
		irq_case(1, 0, 9'h000, CRF_IRQ_HARDFAULT, 9'h005, 1);
		irq_case(0, 1, 9'h000, CRF_IRQ_HARDFAULT, 9'h005, 0);
		irq_case(1, 1, 9'h000, CRF_IRQ_NMI, 9'h005, 1);
		irq_case(0, 0, 9'h004, CRF_IRQ_NORMAL, 9'h004, 0);
		irq_case(0, 0, 9'h004, CRF_IRQ_NORMAL, 9'h003, 1);
		irq_case(0, 0, 9'h100, CRF_IRQ_NORMAL, 9'h1FF, 0);
		$display("test irq done");
	endtask : t_irq
	task automatic t_modes();
		logic [31:0] d;
		wr(CRF_IDX_PROC_SP, 32'h00000100); wr(CRF_IDX_MAIN_SP, 32'h00000200);
		wr(CRF_IDX_CONTROL, 32'h00000003);
		rd(CRF_IDX_SP, d); chk(d, 32'h00000100);
		rd(CRF_IDX_MAIN_SP, d); chk(d, 32'h00000000);
		flt(4);
		i_crf_pipe_model.enter(9'h023);
		rd(CRF_IDX_SP, d); chk(d, 32'h00000200);
		rd(CRF_IDX_CONTROL, d); chk(d, 32'h00000001);
		rd(CRF_IDX_INT, d); chk(d, 32'h00000023);
		rd(CRF_IDX_EVT_STAT, d); chk(d, 32'h00000007);
		chk(evt_irq, 1'b0);
		wr(CRF_IDX_EVT_MASK, 32'h00000001); repeat (2) @(posedge clk_sys);
		#1 chk(evt_irq, 1'b1);
		wr(CRF_IDX_EVT_STAT, 32'h00000007); repeat (2) @(posedge clk_sys);
		#1 chk(evt_irq, 1'b0);
		i_crf_pipe_model.leave();
		rd(CRF_IDX_SP, d); chk(d, 32'h00000100);
		$display("test modes done");
	endtask : t_modes

	// -------------------------------------------------------------
	// Main sequence and watchdog
	// -------------------------------------------------------------
	initial begin
		rst_n = 0; reg_addr = '0; reg_wdata = '0; reg_wr = 0; reg_rd = 0;
		rd_req = '0; wr_req = '0; call_en = 0; call_ret = '0; pc_load = 0; pc_next = '0;
		flags_wr = 0; flags_val = '0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_align();
		t_narrow();
		t_status();
		t_irq();
		t_modes();
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		finish_test();
	end
endmodule : test_crf_core_regs
